/* rtl/pm_capability_regs.sv */
// Purpose: power management capability word and control/status word on APB
// Assumes: APB master on CLK, zero wait states, lock input from core logic
// Notes: reads are sampled in the setup cycle, writes act at the access edge
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module pm_capability_regs
  import pm_cap_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // core side
  input wire logic SPECIAL_INIT_LOCK,
  output logic [PS_FIELD_W-1:0] POWER_STATE,
  output logic SPECIAL_INIT
);

  apb_req_s req;
  bus_strobe_s strobe;
  power_state_e ps_reg;
  logic special_init_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic slverr_reg;
  logic slverr_next;

  // capability word, built from its fields
  function automatic logic [31:0] cap_word(input logic special_init);
    logic [31:0] w;
    w = '0;
    w[CAP_ID_LSB +: 8] = CAP_ID_VALUE;
    w[NEXT_PTR_LSB +: 8] = NEXT_PTR_VALUE;
    w[SPEC_REV_LSB +: 3] = SPEC_REV_VALUE;
    w[LEGACY_CLK_BIT] = 1'b0;
    w[CAP_RSVD_BIT] = 1'b0;
    w[SPECIAL_INIT_BIT] = special_init;
    w[AUX_CUR_LSB +: 3] = AUX_CUR_VALUE;
    w[D1_BIT] = 1'b0;
    w[D2_BIT] = 1'b0;
    w[WAKE_SUP_LSB +: 5] = WAKE_SUP_VALUE;
    return w;
  endfunction

  // control/status word, built from its fields
  function automatic logic [31:0] ctl_word(input power_state_e ps);
    logic [31:0] w;
    w = '0;
    w[PS_FIELD_LSB +: PS_FIELD_W] = ps;
    w[WAKE_EN_BIT] = 1'b0;
    w[PWR_DATA_SEL_LSB +: 4] = PWR_DATA_SEL_VALUE;
    w[PWR_DATA_SCALE_LSB +: 2] = PWR_DATA_SCALE_VALUE;
    w[WAKE_ST_BIT] = 1'b0;
    w[BUS_LOW_PWR_BIT] = 1'b0;
    w[BPCC_BIT] = 1'b0;
    w[PDATA_LSB +: 8] = PDATA_VALUE;
    return w;
  endfunction

  assign req.sel = PSEL;
  assign req.enable = PENABLE;
  assign req.write = PWRITE;
  assign req.addr = PADDR;
  assign req.wdata = PWDATA;
  assign req.strb = PSTRB;

  apb_word_decode u_decode (
    .req(req),
    .strobe(strobe)
  );

  // write strobes, taken at the access edge with the lane enabled
  wire wr_access = strobe.access & strobe.write;
  wire ps_we = wr_access & strobe.hit_ctl & req.strb[PS_FIELD_LANE];
  wire si_we = wr_access & strobe.hit_cap & req.strb[SPECIAL_INIT_LANE];
  wire [PS_FIELD_W-1:0] ps_wdata = req.wdata[PS_FIELD_LSB +: PS_FIELD_W];
  wire si_wdata = req.wdata[SPECIAL_INIT_BIT];

  pm_state_holder u_state (
    .clk(CLK),
    .rst(RST),
    .ps_we(ps_we),
    .ps_wdata(ps_wdata),
    .si_we(si_we),
    .si_wdata(si_wdata),
    .si_lock(SPECIAL_INIT_LOCK),
    .ps_reg(ps_reg),
    .special_init_reg(special_init_reg)
  );

  // read mux; unmapped reads give zero
  wire [31:0] cap_value = cap_word(special_init_reg);
  wire [31:0] ctl_value = ctl_word(ps_reg);
  wire [31:0] read_mux = strobe.hit_cap ? cap_value :
                         strobe.hit_ctl ? ctl_value : 32'h00000000;
  wire rd_setup = strobe.setup & ~strobe.write;

  assign prdata_next = rd_setup ? read_mux : prdata_reg;
  assign slverr_next = strobe.setup ? strobe.unmapped : slverr_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // zero wait states; error only in the access phase
  assign PREADY = strobe.access;
  assign PSLVERR = strobe.access & slverr_reg;
  assign PRDATA = prdata_reg;
  assign POWER_STATE = ps_reg;
  assign SPECIAL_INIT = special_init_reg;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_rd_cap;
    PSEL && !PENABLE && !PWRITE && PADDR == CAP_WORD_OFFSET;
  endsequence

  sequence s_rd_ctl;
    PSEL && !PENABLE && !PWRITE && PADDR == CTL_WORD_OFFSET;
  endsequence

  wire wr_ctl_edge = PSEL && PENABLE && PWRITE && PADDR == CTL_WORD_OFFSET && PSTRB[0];
  wire wr_cap_edge = PSEL && PENABLE && PWRITE && PADDR == CAP_WORD_OFFSET && PSTRB[2];
  wire ps_code_legal = PWDATA[1:0] == PS_D0 || PWDATA[1:0] == PS_D3HOT;
  wire unmapped_addr = PADDR != CAP_WORD_OFFSET && PADDR != CTL_WORD_OFFSET;
  wire rd_access = PSEL && PENABLE && !PWRITE;

  // shadow of the two writable bits, rebuilt from the bus pins and SPECIAL_INIT_LOCK
  logic [PS_FIELD_W-1:0] shadow_ps_reg;
  logic [PS_FIELD_W-1:0] shadow_ps_next;
  logic shadow_si_reg;
  logic shadow_si_next;

  assign shadow_ps_next = (wr_ctl_edge && ps_code_legal) ?
                          PWDATA[PS_FIELD_LSB +: PS_FIELD_W] : shadow_ps_reg;
  assign shadow_si_next = (wr_cap_edge && !SPECIAL_INIT_LOCK) ?
                          PWDATA[SPECIAL_INIT_BIT] : shadow_si_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shadow_ps_reg <= PS_D0;
      shadow_si_reg <= SPECIAL_INIT_RESET;
    end else begin
      shadow_ps_reg <= shadow_ps_next;
      shadow_si_reg <= shadow_si_next;
    end
  end

  property p_cap_id;
    s_rd_cap |=> PRDATA[7:0] == 8'h01;
  endproperty
  a_cap_id: assert property (p_cap_id)
    else $error("capability id is not one");

  property p_next_ptr;
    s_rd_cap |=> PRDATA[15:8] == 8'h00 && PREADY;
  endproperty
  a_next_ptr: assert property (p_next_ptr)
    else $error("next capability pointer not zero");

  property p_spec_rev;
    s_rd_cap ##1 PENABLE |-> PRDATA[18:16] == 3'h2 && !PSLVERR;
  endproperty
  a_spec_rev: assert property (p_spec_rev)
    else $error("specification revision not two");

  property p_na_bits;
    (s_rd_cap |=> PRDATA[19] == 1'b0) and
    (s_rd_ctl |=> PRDATA[23:22] == 2'h0);
  endproperty
  a_na_bits: assert property (p_na_bits)
    else $error("bits that do not apply read nonzero");

  property p_special_init;
    ($past(RST) |-> !special_init_reg) and
    (wr_cap_edge && SPECIAL_INIT_LOCK |=> $stable(special_init_reg)) and
    (wr_cap_edge && !SPECIAL_INIT_LOCK |=> special_init_reg == $past(PWDATA[21]));
  endproperty
  a_special_init: assert property (p_special_init)
    else $error("special init bit reset or lock misbehaves");

  property p_aux_cur;
    s_rd_cap |=> PRDATA[24:22] == 3'h0;
  endproperty
  a_aux_cur: assert property (p_aux_cur)
    else $error("auxiliary current not zero");

  property p_d1_d2;
    s_rd_cap |=> PRDATA[26:25] == 2'h0 && PRDATA[21] == $past(special_init_reg);
  endproperty
  a_d1_d2: assert property (p_d1_d2)
    else $error("intermediate power states advertised");

  property p_wake_sup;
    s_rd_cap |=> PRDATA[31:27] == 5'h00;
  endproperty
  a_wake_sup: assert property (p_wake_sup)
    else $error("wake support field not zero");

  property p_power_state_field;
    ($past(RST) |-> ps_reg == PS_D0) and
    (wr_ctl_edge && ps_code_legal |=> ps_reg == $past(PWDATA[1:0])) and
    (s_rd_ctl |=> PRDATA[1:0] == $past(ps_reg));
  endproperty
  a_power_state_field: assert property (p_power_state_field)
    else $error("power state not stored or read back");

  property p_wake_en;
    s_rd_ctl |=> PRDATA[WAKE_EN_BIT] == 1'b0;
  endproperty
  a_wake_en: assert property (p_wake_en)
    else $error("wake enable took a write");

  property p_wake_st;
    s_rd_ctl |=> PRDATA[15] == 1'b0;
  endproperty
  a_wake_st: assert property (p_wake_st)
    else $error("wake status not zero");

  property p_power_data;
    s_rd_ctl |=> PRDATA[14:9] == 6'h00 && PRDATA[31:24] == 8'h00;
  endproperty
  a_power_data: assert property (p_power_data)
    else $error("power data fields not zero");

  property p_reserved;
    (wr_ctl_edge && !ps_code_legal |=> $stable(ps_reg)) and
    (s_rd_ctl |=> PRDATA[7:2] == 6'h00 && PRDATA[21:16] == 6'h00) and
    (s_rd_cap |=> PRDATA[20] == 1'b0);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code stored or reserved bit set");

  property p_unmapped;
    PSEL && !PENABLE && PADDR != CAP_WORD_OFFSET && PADDR != CTL_WORD_OFFSET ##1 PENABLE
      |-> PSLVERR && PREADY;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access gave no error");

  property p_shadow_ps;
    ps_reg == shadow_ps_reg;
  endproperty
  a_shadow_ps: assert property (p_shadow_ps)
    else $error("stored power state differs from the bus history");

  property p_shadow_si;
    special_init_reg == shadow_si_reg;
  endproperty
  a_shadow_si: assert property (p_shadow_si)
    else $error("special init bit differs from the bus history");

  property p_ps_legal;
    ps_reg == PS_D0 || ps_reg == PS_D3HOT;
  endproperty
  a_ps_legal: assert property (p_ps_legal)
    else $error("reserved power state code is stored");

  property p_pready;
    PREADY == (PSEL && PENABLE);
  endproperty
  a_pready: assert property (p_pready)
    else $error("ready is not high exactly in the access phase");

  property p_slverr_gate;
    !(PSEL && PENABLE) |-> !PSLVERR;
  endproperty
  a_slverr_gate: assert property (p_slverr_gate)
    else $error("error response outside an access phase");

  property p_slverr_mapped;
    PSEL && PENABLE && !unmapped_addr |-> !PSLVERR;
  endproperty
  a_slverr_mapped: assert property (p_slverr_mapped)
    else $error("mapped access answered with an error");

  property p_prdata_hold;
    !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data moved outside a read setup");

  property p_read_no_effect;
    rd_access |=> $stable(ps_reg) && $stable(special_init_reg);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect)
    else $error("a read changed a stored bit");

  property p_unmapped_write;
    PSEL && PENABLE && PWRITE && unmapped_addr |=> $stable(ps_reg) && $stable(special_init_reg);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write changed a stored bit");

  property p_unmapped_read_zero;
    PSEL && !PENABLE && !PWRITE && unmapped_addr |=> PRDATA == 32'h00000000;
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero)
    else $error("unmapped read returned nonzero data");

  property p_lanes;
    (PSEL && PENABLE && PWRITE && PADDR == CTL_WORD_OFFSET && !PSTRB[PS_FIELD_LANE]
      |=> $stable(ps_reg)) and
    (PSEL && PENABLE && PWRITE && PADDR == CAP_WORD_OFFSET && !PSTRB[SPECIAL_INIT_LANE]
      |=> $stable(special_init_reg));
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("write without its byte lane changed a stored bit");

  property p_ctl_upper;
    s_rd_ctl |=> PRDATA[31:PS_FIELD_W] == '0;
  endproperty
  a_ctl_upper: assert property (p_ctl_upper)
    else $error("control word reads nonzero above the power state");

  c_enter_d3hot: cover property (wr_ctl_edge && PWDATA[1:0] == PS_D3HOT ##1 ps_reg == PS_D3HOT);
  c_back_to_d0: cover property (ps_reg == PS_D3HOT ##1 ps_reg == PS_D0);
  c_reserved_code: cover property (wr_ctl_edge && !ps_code_legal);
  c_locked_write: cover property (wr_cap_edge && SPECIAL_INIT_LOCK);
  c_unmapped: cover property (PSLVERR);

endmodule

/* rtl/pm_cap_pkg.sv */
// Purpose: constants, field layout and carrier types of the power management register pair
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes: every field that is not power state or special init is fixed; all but capability id (1) and spec revision (2) are zero
package pm_cap_pkg;

  // register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] CAP_WORD_OFFSET = 12'h0F0;
  localparam logic [11:0] CTL_WORD_OFFSET = 12'h0F4;

  // capability word layout and fixed values
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  localparam int SPEC_REV_LSB = 16;
  localparam int LEGACY_CLK_BIT = 19;
  localparam int CAP_RSVD_BIT = 20;
  localparam int SPECIAL_INIT_BIT = 21;
  localparam int AUX_CUR_LSB = 22;
  localparam int D1_BIT = 25;
  localparam int D2_BIT = 26;
  localparam int WAKE_SUP_LSB = 27;
  localparam logic [7:0] CAP_ID_VALUE = 8'h01;
  localparam logic [7:0] NEXT_PTR_VALUE = 8'h00;
  localparam logic [2:0] SPEC_REV_VALUE = 3'h2;
  localparam logic [2:0] AUX_CUR_VALUE = 3'h0;
  localparam logic [4:0] WAKE_SUP_VALUE = 5'h00;
  localparam logic SPECIAL_INIT_RESET = 1'b0;

  // control/status word layout
  localparam int PS_FIELD_LSB = 0;
  localparam int PS_FIELD_W = 2;
  localparam int WAKE_EN_BIT = 8;
  localparam int PWR_DATA_SEL_LSB = 9;
  localparam int PWR_DATA_SCALE_LSB = 13;
  localparam int WAKE_ST_BIT = 15;
  localparam int BUS_LOW_PWR_BIT = 22;
  localparam int BPCC_BIT = 23;
  localparam int PDATA_LSB = 24;
  localparam logic [3:0] PWR_DATA_SEL_VALUE = 4'h0;
  localparam logic [1:0] PWR_DATA_SCALE_VALUE = 2'h0;
  localparam logic [7:0] PDATA_VALUE = 8'h00;

  // byte lanes that carry writable bits
  localparam int PS_FIELD_LANE = 0;
  localparam int SPECIAL_INIT_LANE = 2;

  typedef enum logic [1:0] {
    PS_D0 = 2'h0,
    PS_D1 = 2'h1,
    PS_D2 = 2'h2,
    PS_D3HOT = 2'h3
  } power_state_e;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } apb_req_s;

  typedef struct packed {
    logic setup;
    logic access;
    logic write;
    logic hit_cap;
    logic hit_ctl;
    logic unmapped;
  } bus_strobe_s;

endpackage

/* rtl/apb_word_decode.sv */
// Purpose: phase and address decode of an APB request
// Assumes: request comes from logic on the same clock
// Notes: purely combinational
`timescale 1ns/1ps
module apb_word_decode
  import pm_cap_pkg::*;
(
  // request
  input apb_req_s req,
  // decoded strobes
  output bus_strobe_s strobe
);

  wire hit_cap = (req.addr == CAP_WORD_OFFSET);
  wire hit_ctl = (req.addr == CTL_WORD_OFFSET);

  assign strobe.setup = req.sel & ~req.enable;
  assign strobe.access = req.sel & req.enable;
  assign strobe.write = req.write;
  assign strobe.hit_cap = hit_cap;
  assign strobe.hit_ctl = hit_ctl;
  assign strobe.unmapped = ~(hit_cap | hit_ctl);

endmodule

/* rtl/pm_state_holder.sv */
// Purpose: the two writable bits of the register pair
// Assumes: write strobes are one-cycle APB access pulses
// Notes: reserved power-state codes are dropped, lock freezes special init
`timescale 1ns/1ps
module pm_state_holder
  import pm_cap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // power state write
  input wire logic ps_we,
  input wire logic [PS_FIELD_W-1:0] ps_wdata,
  // special init write
  input wire logic si_we,
  input wire logic si_wdata,
  input wire logic si_lock,
  // stored values
  output power_state_e ps_reg,
  output logic special_init_reg
);

  // only D0 and D3hot can be stored
  wire ps_code_ok = (ps_wdata == PS_D0) | (ps_wdata == PS_D3HOT);
  wire ps_take = ps_we & ps_code_ok;
  wire si_take = si_we & ~si_lock;
  power_state_e ps_next;
  logic special_init_next;

  assign ps_next = ps_take ? power_state_e'(ps_wdata) : ps_reg;
  assign special_init_next = si_take ? si_wdata : special_init_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_reg <= PS_D0;
      special_init_reg <= SPECIAL_INIT_RESET;
    end else begin
      ps_reg <= ps_next;
      special_init_reg <= special_init_next;
    end
  end

endmodule

/* dv/tb_top.sv */
// Purpose: self-checking bench for the power management register pair on APB
// Assumes: zero-wait slave, reads sampled in setup, writes at the access edge
// Notes: every transfer waits for PREADY under a bounded count
`timescale 1ns/1ps
module tb_top
  import pm_cap_pkg::*;
;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [3:0] PSTRB = 4'h0;
  logic SPECIAL_INIT_LOCK = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [PS_FIELD_W-1:0] POWER_STATE;
  logic SPECIAL_INIT;
  int errors = 0;
  int samples_checked = 0;
  logic [1:0] codes [8] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h3, 2'h0};
  logic [1:0] held [8] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};

  always #10 CLK = ~CLK;

  pm_capability_regs uut (
    .CLK(CLK),
    .RST(RST),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PSTRB(PSTRB),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .SPECIAL_INIT_LOCK(SPECIAL_INIT_LOCK),
    .POWER_STATE(POWER_STATE),
    .SPECIAL_INIT(SPECIAL_INIT)
  );

  task automatic stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one APB transfer: setup, then access held until PREADY is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic ee);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, s, r, e);
    check({31'h0, e}, {31'h0, ee});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0000_0000, 4'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, ee});
  endtask

  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rd(12'h0F0, 32'h0002_0001, 1'b0);
    rd(12'h0F4, 32'h0000_0000, 1'b0);
    check({30'h0, POWER_STATE}, 32'h0000_0000);
    // every code, with all read-only bits set in the same write
    for (int i = 0; i < 8; i++) begin
      wr(12'h0F4, 32'hFFFF_FFFC | {30'h0, codes[i]}, 4'hF, 1'b0);
      rd(12'h0F4, {30'h0, held[i]}, 1'b0);
      check({30'h0, POWER_STATE}, {30'h0, held[i]});
    end
    check({31'h0, SPECIAL_INIT}, 32'h0000_0000);
    // power state lane not strobed
    wr(12'h0F4, 32'h0000_0003, 4'hE, 1'b0);
    rd(12'h0F4, 32'h0000_0000, 1'b0);
    // special init bit, writable while unlocked, frozen while locked
    wr(12'h0F0, 32'hFFFF_FFFF, 4'hF, 1'b0);
    rd(12'h0F0, 32'h0022_0001, 1'b0);
    check({31'h0, SPECIAL_INIT}, 32'h0000_0001);
    SPECIAL_INIT_LOCK <= 1'b1;
    wr(12'h0F0, 32'h0000_0000, 4'hF, 1'b0);
    rd(12'h0F0, 32'h0022_0001, 1'b0);
    SPECIAL_INIT_LOCK <= 1'b0;
    wr(12'h0F0, 32'h0000_0000, 4'hB, 1'b0);
    rd(12'h0F0, 32'h0022_0001, 1'b0);
    wr(12'h0F0, 32'h0000_0000, 4'hF, 1'b0);
    rd(12'h0F0, 32'h0002_0001, 1'b0);
    // unmapped and unaligned places answer with an error and read zero
    rd(12'h0F8, 32'h0000_0000, 1'b1);
    rd(12'h0F2, 32'h0000_0000, 1'b1);
    wr(12'h0F6, 32'h0000_0003, 4'hF, 1'b1);
    rd(12'h0F4, 32'h0000_0000, 1'b0);
    // reset in mid-run returns both writable bits to their defaults
    wr(12'h0F4, 32'h0000_0003, 4'hF, 1'b0);
    wr(12'h0F0, 32'h0020_0000, 4'hF, 1'b0);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    check({30'h0, POWER_STATE}, 32'h0000_0000);
    check({31'h0, SPECIAL_INIT}, 32'h0000_0000);
    RST <= 1'b0;
    rd(12'h0F0, 32'h0002_0001, 1'b0);
    rd(12'h0F4, 32'h0000_0000, 1'b0);
    stop_test();
  end
endmodule
